/* hdl/lsfp_core.sv */
// module: led string fault supervisor for a six-channel boost driver
// Summary of operation
// R1: channel reaching target current becomes good
// R2: good channel dropping below target becomes open
// R3: overvoltage or warm marks non-good channels open
// R4: open channel off after six dimming cycles
// R5: warm die shortens time-out to 800 us
// R6: raised-voltage string kept unless overvoltage reached or die warm
// R7: input undervoltage stops switching, resets state
// R8: serial use: resume only after host re-enable
// R9: pin use: restart itself when voltage recovers
// R10: overcurrent turns switch off rest of cycle
// R11: start only after switch node exceeds 1.2V
// R12: feedback above then below 20% kills protection
// R13: hot trip stops boost and all sinks
// R14: cool restart at 75, then 50, 25 percent
// R15: hot trip sets thermal bit in status
// R16: logic stays alive through thermal faults
// R17: short below 4V stays on
// R18: short above threshold off after six cycles
// R19: threshold select bits 1:0, code 3 disables
// R20: faults reported, mask hides faults of and masks channels
// R21: faulted channel latched off until reset or enable drops
`timescale 1ns/10ps
`default_nettype none
module lsfp_core
(
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_rst,
   input  wire logic                          i_enable,
   input  wire logic                          i_serial_mode,
   input  wire logic                          i_host_enable,
   input  wire logic [1:0]                    i_sc_sel,
   input  wire logic [lsfp_pkg::NUM_CH-1:0]   i_ch_mask,
   input  wire lsfp_pkg::lsfp_ch_cmp_t        i_ch_cmp,
   input  wire lsfp_pkg::lsfp_sys_cmp_t       i_sys_cmp,
   output logic [lsfp_pkg::NUM_CH-1:0]        o_ch_on,
   output logic [lsfp_pkg::NUM_CH-1:0]        o_ch_failed,
   output logic                               o_boost_en,
   output logic                               o_sw_gate,
   output logic                               o_lx_test,
   output logic                               o_prot_fet_off,
   output logic [6:0]                         o_level,
   output logic [7:0]                         o_fault_reg
);
   localparam int N  = lsfp_pkg::NUM_CH;
   localparam int HW = lsfp_pkg::HOT_CNT_W;

   // three-stage synchronisers; a change is taken once stages 2 and 3 agree
   localparam int SW = 4 * N + 10;
   logic [SW-1:0] raw;
   logic [SW-1:0] sy1;
   logic [SW-1:0] sy2;
   logic [SW-1:0] sy3;
   logic [SW-1:0] filt;
   assign raw = {i_ch_cmp, i_sys_cmp};

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sy1  <= '0;
         sy2  <= '0;
         sy3  <= '0;
         filt <= '0;
      end
      else
      begin
         sy1 <= raw;
         sy2 <= sy1;
         sy3 <= sy2;
         for (int k = 0; k < SW; k++)
            if (sy2[k] == sy3[k])
               filt[k] <= sy3[k];
      end
   end

   lsfp_pkg::lsfp_ch_cmp_t  ch;
   lsfp_pkg::lsfp_sys_cmp_t sys;
   assign {ch, sys} = filt;

   // picks the short comparator that matches the selected threshold
   function automatic logic [N-1:0] sc_pick(input logic [1:0] sel,
                                            input lsfp_pkg::lsfp_ch_cmp_t c);
      case (sel)
         lsfp_pkg::SC_SEL_LOW:  sc_pick = c.sc_low;
         lsfp_pkg::SC_SEL_MID:  sc_pick = c.sc_mid;
         lsfp_pkg::SC_SEL_HIGH: sc_pick = c.sc_high;
         default:               sc_pick = '0;
      endcase
   endfunction

   function automatic logic [6:0] step_level(input logic [1:0] s);
      case (s)
         2'h0:    step_level = lsfp_pkg::LVL_FULL;
         2'h1:    step_level = lsfp_pkg::LVL_75;
         2'h2:    step_level = lsfp_pkg::LVL_50;
         default: step_level = lsfp_pkg::LVL_25;
      endcase
   endfunction

   lsfp_pkg::lsfp_state_s_t s;
   lsfp_pkg::lsfp_state_s_t next_s;

   logic [N-1:0] short_hit;
   logic         pwm_rise;
   logic         hot_rise;
   logic         allowed;
   logic         running;
   assign short_hit = sc_pick(i_sc_sel, ch);                       // [R19]
   assign pwm_rise  = sys.pwm & ~s.pwm_d;
   assign hot_rise  = sys.temp_high & ~s.temp_high_d;
   // serial use needs a fresh host enable after lockout; pin use does not
   assign allowed   = i_enable & (i_serial_mode ? i_host_enable    // [R8]
                                                : 1'b1);           // [R9]
   assign running   = (s.st == lsfp_pkg::LSFP_RUN);

   always_comb
   begin
      next_s             = s;
      next_s.pwm_d       = sys.pwm;
      next_s.temp_high_d = sys.temp_high;

      // cycle-by-cycle current limit; cleared at each new switching cycle
      if (sys.sw_cycle)
         next_s.sw_gate = 1'b1;
      if (sys.ilim)
         next_s.sw_gate = 1'b0;                                    // [R10]

      // feedback excursion: above 20% then back below; only armed while
      // running, since feedback starts low and the filter resets to zero
      if (running && !sys.fb_low)
         next_s.fb_seen = 1'b1;
      if (s.fb_seen && sys.fb_low)
         next_s.prot_off = 1'b1;                                   // [R12]

      if (i_serial_mode && !i_host_enable)
         next_s.input_undervoltage_lockout_rst = 1'b0;

      if (hot_rise)
      begin
         next_s.fault_reg[lsfp_pkg::FAULT_THERM_BIT] = 1'b1;       // [R15]
         if (s.therm_step != 2'h3)
            next_s.therm_step = s.therm_step + 2'h1;               // [R14]
      end

      case (s.st)
         lsfp_pkg::LSFP_OFF:
         begin
            if (allowed && !sys.input_undervoltage_lockout && !s.input_undervoltage_lockout_rst)
               next_s.st = lsfp_pkg::LSFP_SW_CHECK;
         end
         lsfp_pkg::LSFP_SW_CHECK:
         begin
            if (sys.lx_ok)
               next_s.st = lsfp_pkg::LSFP_RUN;                     // [R11]
         end
         lsfp_pkg::LSFP_RUN:
         begin
            for (int k = 0; k < N; k++)
            begin
               if (ch.at_target[k])
                  next_s.good[k] = 1'b1;                           // [R1]
               else if (s.good[k])
                  next_s.open[k] = 1'b1;                           // [R2]
               // a zener string still conducts, so only overvoltage or a warm die opens it
               if ((sys.output_overvoltage_limit || sys.temp_low) && !s.good[k])
                  next_s.open[k] = 1'b1;                           // [R3] [R6]
               // a short below threshold stays lit
               if (s.open[k] || short_hit[k])                      // [R17]
               begin
                  if (pwm_rise && s.pwm_cnt[k] != lsfp_pkg::OPEN_PWM_CYCLES)
                     next_s.pwm_cnt[k] = s.pwm_cnt[k] + 3'h1;
                  if (sys.temp_low &&
                      s.hot_cnt[k] != HW'(lsfp_pkg::HOT_TIMEOUT_CYC))
                     next_s.hot_cnt[k] = s.hot_cnt[k] + HW'(1);
                  if (s.pwm_cnt[k] == lsfp_pkg::OPEN_PWM_CYCLES ||
                      s.hot_cnt[k] == HW'(lsfp_pkg::HOT_TIMEOUT_CYC))
                     next_s.dis[k] = 1'b1;                  // [R4] [R5] [R18]
               end
               else
               begin
                  next_s.pwm_cnt[k] = '0;
                  next_s.hot_cnt[k] = '0;
               end
            end
            if (hot_rise)
               next_s.st = lsfp_pkg::LSFP_THERM_OFF;               // [R13]
         end
         lsfp_pkg::LSFP_THERM_OFF:
         begin
            if (sys.temp_cool && !sys.temp_high)
               next_s.st = lsfp_pkg::LSFP_RUN;                     // [R14]
         end
         default:
            next_s.st = lsfp_pkg::LSFP_OFF;
      endcase

      // undervoltage or disable: stop and clear run state, keep fault record
      if (sys.input_undervoltage_lockout || !allowed)
      begin
         next_s.st       = lsfp_pkg::LSFP_OFF;                     // [R7]
         next_s.good     = '0;
         next_s.open     = '0;
         next_s.pwm_cnt  = '0;
         next_s.hot_cnt  = '0;
         next_s.fb_seen  = 1'b0;
         next_s.input_undervoltage_lockout_rst = sys.input_undervoltage_lockout & i_serial_mode;               // [R8]
         if (!i_enable)
         begin
            next_s.dis        = '0;                                // [R21]
            next_s.therm_step = '0;
            next_s.prot_off   = 1'b0;
         end
      end
      if (s.prot_off)
         next_s.st = lsfp_pkg::LSFP_LOCKED;

      next_s.boost_en = (next_s.st == lsfp_pkg::LSFP_RUN) && !sys.input_undervoltage_lockout;
      next_s.ch_on    = (next_s.st == lsfp_pkg::LSFP_RUN)
                        ? ~(next_s.dis | i_ch_mask) : '0;          // [R20]
      next_s.level    = step_level(next_s.therm_step);
      // bit 0 any unmasked channel fault, bit 1 thermal, bit 2 overvoltage
      next_s.fault_reg[0] = s.fault_reg[0] | (|(next_s.dis & ~i_ch_mask));
      next_s.fault_reg[2] = s.fault_reg[2] | (running & sys.output_overvoltage_limit);
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s    <= '0;
         s.st <= lsfp_pkg::LSFP_OFF;
         s.sw_gate <= 1'b1;
      end
      else
         s <= next_s;
   end

   // logic stays clocked in every state so status is always readable [R16]
   assign o_ch_on        = s.ch_on;
   assign o_ch_failed    = s.dis;
   assign o_boost_en     = s.boost_en;
   assign o_sw_gate      = s.sw_gate;
   assign o_lx_test      = (s.st == lsfp_pkg::LSFP_SW_CHECK);
   assign o_prot_fet_off = s.prot_off;
   assign o_level        = s.level;
   assign o_fault_reg    = s.fault_reg;

   sticky_dis_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s.dis != '0 && i_enable) |=> (s.dis & $past(s.dis)) == $past(s.dis))
      else $error("disabled channel came back on"); // [R21]
   therm_bit_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      hot_rise |=> s.fault_reg[lsfp_pkg::FAULT_THERM_BIT])
      else $error("thermal bit not set"); // [R15]
   therm_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (running && hot_rise && !sys.input_undervoltage_lockout && i_enable && !s.prot_off)
      |=> ##1 (o_ch_on == '0 && !o_boost_en))
      else $error("hot trip left sinks on"); // [R13]
   ilim_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      sys.ilim |=> !s.sw_gate)
      else $error("switch not cut on overcurrent"); // [R10]
   input_undervoltage_lockout_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      sys.input_undervoltage_lockout |=> ##1 !o_boost_en)
      else $error("boost runs under lockout"); // [R7]
   lx_wait_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s.st == lsfp_pkg::LSFP_SW_CHECK && !sys.lx_ok)
      |=> s.st != lsfp_pkg::LSFP_RUN)
      else $error("started without node check"); // [R11]
   good_open_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (running && s.good[2] && !ch.at_target[2] && allowed && !sys.input_undervoltage_lockout)
      |=> s.open[2])
      else $error("good channel not reclassified"); // [R2]
   prot_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s.fb_seen && sys.fb_low) |=> ##1 o_prot_fet_off)
      else $error("protection transistor still on"); // [R12]
   level_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s.therm_step == 2'h1) |-> ##1 (o_level == lsfp_pkg::LVL_75 ||
                                      s.therm_step != 2'h1))
      else $error("wrong derated level"); // [R14]

   run_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      s.st == lsfp_pkg::LSFP_RUN);
   dis_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      s.dis[0]);
   therm_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      s.therm_step == 2'h3);
endmodule // lsfp_core
`default_nettype wire

/* hdl/lsfp_pkg.sv */
// package: constants and carrier types for the led string fault supervisor
package lsfp_pkg;
   localparam int          NUM_CH          = 6;
   localparam int          CLK_MHZ         = 250;
   // open channel time-out in dimming cycles
   localparam logic [2:0]  OPEN_PWM_CYCLES = 3'h6;
   // shortened time-out while hot, in microseconds
   localparam int          HOT_TIMEOUT_US  = 800;
   localparam int          HOT_TIMEOUT_CYC = HOT_TIMEOUT_US * CLK_MHZ;
   localparam int          HOT_CNT_W       = 18;
   // thermal current steps, in percent of setting
   localparam logic [6:0]  LVL_FULL        = 7'h64;
   localparam logic [6:0]  LVL_75          = 7'h4B;
   localparam logic [6:0]  LVL_50          = 7'h32;
   localparam logic [6:0]  LVL_25          = 7'h19;
   // fault and status register and its thermal bit
   localparam logic [7:0]  FAULT_REG_IDX   = 8'h02;
   localparam int          FAULT_THERM_BIT = 1;
   localparam logic [7:0]  CFG_REG_IDX     = 8'h08;
   localparam logic [7:0]  MASK_REG_IDX    = 8'h09;
   // short threshold select codes, bits 1:0 of the configuration register
   localparam logic [1:0]  SC_SEL_LOW      = 2'h0;
   localparam logic [1:0]  SC_SEL_MID      = 2'h1;
   localparam logic [1:0]  SC_SEL_HIGH     = 2'h2;
   localparam logic [1:0]  SC_SEL_OFF      = 2'h3;

   typedef enum logic [2:0] {
      LSFP_OFF,
      LSFP_SW_CHECK,
      LSFP_RUN,
      LSFP_THERM_OFF,
      LSFP_LOCKED
   } lsfp_state_t;

   // per-channel comparator results, synchronised inside the core
   typedef struct packed {
      logic [NUM_CH-1:0] at_target;
      logic [NUM_CH-1:0] sc_low;
      logic [NUM_CH-1:0] sc_mid;
      logic [NUM_CH-1:0] sc_high;
   } lsfp_ch_cmp_t;

   typedef struct packed {
      logic output_overvoltage_limit;
      logic fb_low;
      logic input_undervoltage_lockout;
      logic ilim;
      logic lx_ok;
      logic temp_low;
      logic temp_high;
      logic temp_cool;
      logic pwm;
      logic sw_cycle;
   } lsfp_sys_cmp_t;

   typedef struct packed {
      lsfp_state_t             st;
      logic [NUM_CH-1:0]       good;
      logic [NUM_CH-1:0]       open;
      logic [NUM_CH-1:0]       dis;
      logic [NUM_CH-1:0][2:0]  pwm_cnt;
      logic [NUM_CH-1:0][HOT_CNT_W-1:0] hot_cnt;
      logic [1:0]              therm_step;
      logic                    therm_flag;
      logic                    fb_seen;
      logic                    prot_off;
      logic                    sw_gate;
      logic                    pwm_d;
      logic                    temp_high_d;
      logic                    input_undervoltage_lockout_rst;
      logic [NUM_CH-1:0]       ch_on;
      logic                    boost_en;
      logic [6:0]              level;
      logic [7:0]              fault_reg;
   } lsfp_state_s_t;
endpackage

/* verif/led_string_fault_protection_tb.sv */
// self-checking bench for the led string fault supervisor
`timescale 1ns/10ps
`default_nettype none
module led_string_fault_protection_tb;
   logic                    i_ref_clk     = 1'b0;
   logic                    i_rst         = 1'b1;
   logic                    i_enable      = 1'b0;
   logic                    i_serial_mode = 1'b0;
   logic                    reenable      = 1'b0;
   logic                    host_en;
   logic [1:0]              i_sc_sel      = lsfp_pkg::SC_SEL_OFF;
   logic [5:0]              i_ch_mask     = 6'h01;
   lsfp_pkg::lsfp_ch_cmp_t  ch            = '0;
   lsfp_pkg::lsfp_sys_cmp_t sy            = '0;
   logic [5:0]              ch_on;
   logic [5:0]              ch_failed;
   logic                    boost_en;
   logic                    sw_gate;
   logic                    lx_test;
   logic                    prot_off;
   logic [6:0]              level;
   logic [7:0]              fault_reg;
   int                      miscompares   = 0;
   int                      tests_run     = 0;
   int                      cycles        = 0;
   logic [6:0]              lvl_exp [3];

   always #2 i_ref_clk = ~i_ref_clk;

   lsfp_core dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_enable(i_enable),
      .i_serial_mode(i_serial_mode), .i_host_enable(host_en),
      .i_sc_sel(i_sc_sel), .i_ch_mask(i_ch_mask), .i_ch_cmp(ch),
      .i_sys_cmp(sy), .o_ch_on(ch_on), .o_ch_failed(ch_failed),
      .o_boost_en(boost_en), .o_sw_gate(sw_gate), .o_lx_test(lx_test),
      .o_prot_fet_off(prot_off), .o_level(level), .o_fault_reg(fault_reg));

   lsfp_host_model host (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_reenable(reenable), .o_host_enable(host_en));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask

   // pulses held four cycles so the input filter sees each one
   task automatic pulses(input int n);
      repeat (n)
      begin
         sy.pwm <= 1'b1;
         tick(4);
         sy.pwm <= 1'b0;
         tick(4);
      end
   endtask

   task automatic summarize();
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // channel 4 never reaches target, channel 0 is masked by the host
   task automatic start_up();
      i_rst <= 1'b0;
      i_enable <= 1'b1;
      ch.at_target <= 6'h2F;
      sy.fb_low <= 1'b1;
      tick(10);
      check(8'(lx_test), 8'h01);
      check(8'(boost_en), 8'h00);
      sy.lx_ok <= 1'b1;
      tick(10);
      check(8'(boost_en), 8'h01);
      check(8'(ch_on), 8'h3E);
      sy.fb_low <= 1'b0;
   endtask

   task automatic open_and_ovp();
      ch.at_target[2] <= 1'b0;
      tick(8);
      pulses(5);
      check(8'(ch_on), 8'h3E);
      pulses(1);
      check(8'(ch_on), 8'h3A);
      check(8'(ch_failed), 8'h04);
      check(8'(fault_reg[0]), 8'h01);
      ch.at_target[2] <= 1'b1;
      pulses(6);
      check(8'(ch_on), 8'h3A);
      sy.output_overvoltage_limit <= 1'b1;
      tick(6);
      sy.output_overvoltage_limit <= 1'b0;
      pulses(6);
      check(8'(ch_on), 8'h2A);
      check(8'(fault_reg[2]), 8'h01);
   endtask

   task automatic short_ch();
      ch.sc_low <= 6'h02;
      ch.sc_mid <= 6'h02;
      ch.sc_high <= 6'h02;
      pulses(6);
      check(8'(ch_on), 8'h2A);
      i_sc_sel <= lsfp_pkg::SC_SEL_MID;
      pulses(6);
      check(8'(ch_on), 8'h28);
      check(8'(ch_failed), 8'h16);
   endtask

   task automatic switch_limit();
      sy.ilim <= 1'b1;
      tick(8);
      check(8'(sw_gate), 8'h00);
      sy.ilim <= 1'b0;
      tick(8);
      check(8'(sw_gate), 8'h00);
      sy.sw_cycle <= 1'b1;
      tick(6);
      sy.sw_cycle <= 1'b0;
      tick(4);
      check(8'(sw_gate), 8'h01);
   endtask

   // pin use restarts alone, serial use waits for the host
   task automatic undervoltage(input logic serial);
      i_serial_mode <= serial;
      sy.input_undervoltage_lockout <= 1'b1;
      tick(10);
      check(8'(boost_en), 8'h00);
      check(8'(ch_failed), 8'h16);
      sy.input_undervoltage_lockout <= 1'b0;
      tick(20);
      check(8'(boost_en), 8'(!serial));
      reenable <= 1'b1;
      tick(20);
      check(8'(boost_en), 8'h01);
      reenable <= 1'b0;
   endtask

   task automatic thermal();
      lvl_exp = '{lsfp_pkg::LVL_75, lsfp_pkg::LVL_50, lsfp_pkg::LVL_25};
      check(8'(level), 8'(lsfp_pkg::LVL_FULL));
      for (int k = 0; k < 3; k++)
      begin
         sy.temp_high <= 1'b1;
         tick(8);
         check(8'(boost_en), 8'h00);
         check(8'(ch_on), 8'h00);
         check(8'(fault_reg[1]), 8'h01);
         sy.temp_high <= 1'b0;
         sy.temp_cool <= 1'b1;
         tick(10);
         check(8'(level), 8'(lvl_exp[k]));
         sy.temp_cool <= 1'b0;
         tick(4);
      end
   endtask

   task automatic feedback_drop();
      check(8'(prot_off), 8'h00);
      sy.fb_low <= 1'b1;
      tick(8);
      check(8'(prot_off), 8'h01);
   endtask

   // whole run needs about 490 cycles
   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         miscompares++;
         summarize();
      end
   end

   initial
   begin
      tick(12);
      start_up();
      open_and_ovp();
      short_ch();
      switch_limit();
      undervoltage(1'b0);
      undervoltage(1'b1);
      thermal();
      feedback_drop();
      summarize();
   end
endmodule // led_string_fault_protection_tb
`default_nettype wire

/* verif/lsfp_host_model.sv */
// host side model: re-enables the driver over its serial control line
`timescale 1ns/10ps
`default_nettype none
module lsfp_host_model
(
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_reenable,
   output logic      o_host_enable
);
   logic [2:0] low_cnt;
   logic       req_d;

   // a request drops the enable for four cycles, then raises it again
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         low_cnt       <= 3'h0;
         req_d         <= 1'b0;
         o_host_enable <= 1'b1;
      end
      else
      begin
         req_d <= i_reenable;
         if (i_reenable && !req_d)
         begin
            low_cnt       <= 3'h4;
            o_host_enable <= 1'b0;
         end
         else if (low_cnt != 3'h0)
         begin
            low_cnt <= low_cnt - 3'h1;
            if (low_cnt == 3'h1)
               o_host_enable <= 1'b1;
         end
      end
   end
endmodule // lsfp_host_model
`default_nettype wire
